// File: verilog/wff_pkg.sv
/*
 wff_pkg: constants for the wake-frame filter and power-event block.
 assumes: a plain register port with 6-bit word index addressing.
*/
package wff_pkg;
	// ----------------------------------------------------------------
	// register map (word indices)
	// ----------------------------------------------------------------
	localparam logic [5:0] ADDR_MASK0 = 6'h19; // byte mask filter 0, 1..3 follow
	localparam logic [5:0] ADDR_OFFSETS = 6'h1d; // wake_filter_offsets
	localparam logic [5:0] ADDR_CRC_LO = 6'h1e; // wake_filter_crc_low_pair
	localparam logic [5:0] ADDR_CRC_HI = 6'h1f; // wake_filter_crc_high_pair
	localparam logic [5:0] ADDR_PMCSR = 6'h20; // power_mgmt_ctrl_status
	localparam logic [5:0] ADDR_HOST_STAT = 6'h05; // host_status_reg
	localparam logic [5:0] ADDR_WAKE_ID_LO = 6'h21; // wake ident address bytes 3..0
	localparam logic [5:0] ADDR_WAKE_ID_HI = 6'h22; // wake ident address bytes 5..4
	// ----------------------------------------------------------------
	// field layout
	// ----------------------------------------------------------------
	localparam int NUM_FILTERS = 4;
	localparam int OFS_W = 7;
	localparam int FILT_STRIDE = 8; // offset + enable per filter
	localparam int EN_BIT = 7; // enable above the offset
	localparam int CRC_W = 16;
	localparam int WIN_BYTES = 32;
	localparam int PM_STATE_LSB = 0;
	localparam int PM_ENABLE_BIT = 8;
	localparam int PM_STATUS_BIT = 15;
	localparam int HOST_WAKE_BIT = 28;
	// ----------------------------------------------------------------
	// crc-16 settings, seed and order easy to change
	// ----------------------------------------------------------------
	localparam logic [15:0] CRC_POLY = 16'h8005; // x16+x15+x2+1
	localparam logic [15:0] CRC_POLY_REV = 16'ha001; // reflected form
	localparam logic [15:0] CRC_SEED = 16'hffff;
	localparam bit CRC_LSB_FIRST = 1'b1;
	localparam logic [31:0] RESET_WORD = 32'h0000_0000;
	localparam logic [1:0] PM_D0 = 2'h0;
	// power states
	typedef enum logic [1:0] {PS_D0, PS_D1, PS_D2, PS_D3} wff_pstate_t;
endpackage

// File: verilog/wff_crc_unit.sv
/*
 wff_crc_unit: one pattern filter, crc-16 over masked bytes of a frame.
 assumes: bytes arrive one per cycle after a start marker in the cycle before the first.
*/
`timescale 1ns/1ns
module wff_crc_unit
	import wff_pkg::*;
(
	// clock and reset
	input wire logic ref_clk,
	input wire logic reset_n,
	// setup
	input wire logic [OFS_W-1:0] offset,
	input wire logic [31:0] byteMask,
	// byte stream
	input wire logic frameStart,
	input wire logic byteValid,
	input wire logic [7:0] byteData,
	// result
	output logic [CRC_W-1:0] crcOut
);
	// ----------------------------------------------------------------
	// one byte step of the crc, order chosen in the package
	// ----------------------------------------------------------------
	function automatic logic [15:0] crcByte(input logic [15:0] c, input logic [7:0] b);
		logic [15:0] r;
		r = c;
		for (int i = 0; i < 8; i++) begin
			if (CRC_LSB_FIRST) begin
				r = ((r[0] ^ b[i]) != 1'b0) ? ((r >> 1) ^ CRC_POLY_REV) : (r >> 1);
			end else begin
				r = ((r[15] ^ b[7-i]) != 1'b0) ? ((r << 1) ^ CRC_POLY) : (r << 1);
			end
		end
		return r;
	endfunction

	logic [7:0] pos_q, pos_d; // byte position in frame
	logic [15:0] crc_q, crc_d; // running remainder
	logic [7:0] rel; // position relative to offset

	// next state: count bytes, fold in masked ones inside the window
	always_comb begin
		rel = pos_q - {1'b0, offset};
		pos_d = pos_q;
		crc_d = crc_q;
		if (frameStart) begin
			pos_d = 8'h00;
			crc_d = CRC_SEED;
		end else if (byteValid) begin
			if (pos_q != 8'hff) begin
				pos_d = pos_q + 8'h01;
			end
			// window of 32 bytes, mask bit j selects offset+j
			if (pos_q >= {1'b0, offset} && rel < 8'(WIN_BYTES) && byteMask[rel[4:0]]) begin
				crc_d = crcByte(crc_q, byteData);
			end
		end
	end

	// registers
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			pos_q <= 8'h00;
			crc_q <= CRC_SEED;
		end else begin
			pos_q <= pos_d;
			crc_q <= crc_d;
		end
	end

	assign crcOut = crc_q;
endmodule

// File: verilog/wff_wake_filter.sv
/*
 wff_wake_filter: four crc-16 pattern filters, power state register
 and wake event outputs of the network controller.
 assumes: register port strobes last one cycle; the receive path marks
 frame start, each byte, and frame end with address and crc-32 status.
*/
// Function
// - four 7-bit pattern offsets in one register
// - enable bit above each offset gates filter
// - crc register one holds filters 0 and 1
// - crc match of masked bytes means wake
// - crc register two holds filters 2 and 3
// - four power states, d0 to d3
// - power event context kept across power loss
// - magic, pattern and link change wake causes
// - wake address loaded from serial memory
// - receive path stays alive while asleep
// - wake sets power event status bit 15
// - wake sets host status bit 28
// - wake drives pci interrupt low
// - wake drives power event pin low
// - 32-byte window, mask bit per byte
// - crc polynomial x16+x15+x2+1
// - pattern wake needs sleep, enable, address, good crc
`timescale 1ns/1ns
module wff_wake_filter
	import wff_pkg::*;
#(
	parameter int NFILT = NUM_FILTERS
)(
	// clock and reset
	input wire logic ref_clk,
	input wire logic reset_n,
	// register port
	input wire logic [5:0] regAddr,
	input wire logic [31:0] regWdata,
	input wire logic regWr,
	input wire logic regRd,
	output logic [31:0] regRdata,
	// receive path
	input wire logic rxFrameStart,
	input wire logic rxByteValid,
	input wire logic [7:0] rxByteData,
	input wire logic rxFrameEnd,
	input wire logic rxAddrMatch,
	input wire logic rxCrc32Err,
	input wire logic magicDetect,
	input wire logic linkChange,
	// serial memory load of wake address
	input wire logic idLoadValid,
	input wire logic [47:0] idLoadData,
	// wake outputs
	output logic intA_n,
	output logic power_event_out_n,
	output logic rxAlive,
	output logic [47:0] wake_ident_address
);
	// ----------------------------------------------------------------
	// register state
	// ----------------------------------------------------------------
	logic [31:0] mask_q [NFILT]; // per-filter byte masks
	logic [31:0] mask_d [NFILT];
	logic [31:0] ofs_q, ofs_d; // offsets and enables
	logic [31:0] crcLo_q, crcLo_d; // expected crc filters 0,1
	logic [31:0] crcHi_q, crcHi_d; // expected crc filters 2,3
	logic [1:0] pstate_q, pstate_d; // power state field
	logic power_event_enable_q, power_event_enable_d; // power_event_enable
	logic pmStat_q, pmStat_d; // power event status
	logic wakeI_q, wakeI_d; // wakeup_intr_flag
	logic [47:0] wid_q, wid_d; // wake ident address
	logic [31:0] rd_q, rd_d; // read data
	logic intA_q, intA_d, pme_q, pme_d, alive_q, alive_d;
	logic [CRC_W-1:0] crcRes [NFILT]; // per-filter remainders
	logic [CRC_W-1:0] crcExp [NFILT]; // per-filter expected
	logic [NFILT-1:0] hit; // per-filter match
	logic asleep, patWake, wakeEv;

	// ----------------------------------------------------------------
	// filters
	// ----------------------------------------------------------------
	// expected remainders, low half for the even filter of each pair
	assign crcExp[0] = crcLo_q[0 +: CRC_W];
	assign crcExp[1] = crcLo_q[CRC_W +: CRC_W];
	assign crcExp[2] = crcHi_q[0 +: CRC_W];
	assign crcExp[3] = crcHi_q[CRC_W +: CRC_W];

	genvar g;
	generate
		for (g = 0; g < NFILT; g++) begin : gFilt
			// one crc engine per filter, offset from the packed register
			wff_crc_unit uCrc (
				.ref_clk(ref_clk),
				.reset_n(reset_n),
				.offset(ofs_q[g*FILT_STRIDE +: OFS_W]),
				.byteMask(mask_q[g]),
				.frameStart(rxFrameStart),
				.byteValid(rxByteValid),
				.byteData(rxByteData),
				.crcOut(crcRes[g])
			);
			// enabled filter with matching remainder
			assign hit[g] = ofs_q[g*FILT_STRIDE + EN_BIT] && (crcRes[g] == crcExp[g]);
		end
	endgenerate

	// not in d0 and power events enabled
	assign asleep = (pstate_q != PM_D0) && power_event_enable_q;
	// the frame end must trail the last byte by a cycle, or that byte
	// never reaches the remainders and a good frame is missed
	// pattern wake qualified at frame end
	assign patWake = rxFrameEnd && asleep && rxAddrMatch && !rxCrc32Err && (|hit);
	assign wakeEv = asleep && (patWake || magicDetect || linkChange);

	// ----------------------------------------------------------------
	// register next values
	// ----------------------------------------------------------------
	always_comb begin
		mask_d = mask_q;
		ofs_d = ofs_q;
		crcLo_d = crcLo_q;
		crcHi_d = crcHi_q;
		pstate_d = pstate_q;
		power_event_enable_d = power_event_enable_q;
		pmStat_d = pmStat_q;
		wakeI_d = wakeI_q;
		wid_d = wid_q;
		rd_d = RESET_WORD;
		// software writes
		if (regWr) begin
			for (int i = 0; i < NFILT; i++) begin
				if (regAddr == ADDR_MASK0 + 6'(i)) begin
					mask_d[i] = regWdata;
				end
			end
			unique case (regAddr)
				ADDR_OFFSETS: ofs_d = regWdata;
				ADDR_CRC_LO: crcLo_d = regWdata;
				ADDR_CRC_HI: crcHi_d = regWdata;
				ADDR_PMCSR: begin
					// enable and state written by software
					power_event_enable_d = regWdata[PM_ENABLE_BIT];
					pstate_d = regWdata[PM_STATE_LSB +: 2];
					if (regWdata[PM_STATUS_BIT]) begin
						pmStat_d = 1'b0; // write one clears
					end
				end
				ADDR_HOST_STAT: begin
					if (regWdata[HOST_WAKE_BIT]) begin
						wakeI_d = 1'b0; // write one clears
					end
				end
				default: ;
			endcase
		end
		// address from serial memory, no software needed
		if (idLoadValid) begin
			wid_d = idLoadData;
		end
		// set wins over clear
		if (wakeEv) begin
			pmStat_d = 1'b1;
			wakeI_d = 1'b1;
		end
		// software reads, data next cycle
		if (regRd) begin
			for (int i = 0; i < NFILT; i++) begin
				if (regAddr == ADDR_MASK0 + 6'(i)) begin
					rd_d = mask_q[i];
				end
			end
			unique case (regAddr)
				ADDR_OFFSETS: rd_d = ofs_q;
				ADDR_CRC_LO: rd_d = crcLo_q;
				ADDR_CRC_HI: rd_d = crcHi_q;
				ADDR_PMCSR: begin
					rd_d[PM_STATE_LSB +: 2] = pstate_q;
					rd_d[PM_ENABLE_BIT] = power_event_enable_q;
					rd_d[PM_STATUS_BIT] = pmStat_q;
				end
				ADDR_HOST_STAT: rd_d[HOST_WAKE_BIT] = wakeI_q;
				ADDR_WAKE_ID_LO: rd_d = wid_q[31:0];
				ADDR_WAKE_ID_HI: rd_d = {16'h0000, wid_q[47:32]};
				default: ;
			endcase
		end
		// output pins follow the flags
		intA_d = !wakeI_d;
		pme_d = !pmStat_d;
		alive_d = 1'b1; // receive path kept on in every state
	end

	// ----------------------------------------------------------------
	// registers; context lives on the auxiliary-supply reset
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			for (int i = 0; i < NFILT; i++) begin
				mask_q[i] <= RESET_WORD;
			end
			ofs_q <= RESET_WORD;
			crcLo_q <= RESET_WORD;
			crcHi_q <= RESET_WORD;
			pstate_q <= PM_D0;
			power_event_enable_q <= 1'b0;
			pmStat_q <= 1'b0;
			wakeI_q <= 1'b0;
			wid_q <= 48'h0000_0000_0000;
			rd_q <= RESET_WORD;
			intA_q <= 1'b1;
			pme_q <= 1'b1;
			alive_q <= 1'b1;
		end else begin
			mask_q <= mask_d;
			ofs_q <= ofs_d;
			crcLo_q <= crcLo_d;
			crcHi_q <= crcHi_d;
			pstate_q <= pstate_d;
			power_event_enable_q <= power_event_enable_d;
			pmStat_q <= pmStat_d;
			wakeI_q <= wakeI_d;
			wid_q <= wid_d;
			rd_q <= rd_d;
			intA_q <= intA_d;
			pme_q <= pme_d;
			alive_q <= alive_d;
		end
	end

	assign regRdata = rd_q;
	assign intA_n = intA_q;
	assign power_event_out_n = pme_q;
	assign rxAlive = alive_q;
	assign wake_ident_address = wid_q;

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	sequence sWake;
		wakeEv;
	endsequence
	sequence sPinsLow;
		!intA_n && !power_event_out_n;
	endsequence

	a_status_set: assert property (@(posedge ref_clk) disable iff (!reset_n)
		wakeEv |=> pmStat_q) else $error("power event status not set");
	a_host_flag: assert property (@(posedge ref_clk) disable iff (!reset_n)
		wakeEv |=> wakeI_q) else $error("host wake flag not set");
	a_pins_low: assert property (@(posedge ref_clk) disable iff (!reset_n)
		sWake |=> sPinsLow) else $error("wake pins not low");
	a_pme_tracks: assert property (@(posedge ref_clk) disable iff (!reset_n)
		power_event_out_n == !pmStat_q) else $error("pme pin not tracking status");
	a_no_wake_d0: assert property (@(posedge ref_clk) disable iff (!reset_n)
		(pstate_q == PM_D0) |-> !wakeEv) else $error("wake in fully on state");
	a_crc_err_block: assert property (@(posedge ref_clk) disable iff (!reset_n)
		(rxCrc32Err || !rxAddrMatch) |-> !patWake) else $error("bad frame woke");
	a_filt_gated: assert property (@(posedge ref_clk) disable iff (!reset_n)
		!ofs_q[EN_BIT] |-> !hit[0]) else $error("disabled filter matched");
	a_ofs_write: assert property (@(posedge ref_clk) disable iff (!reset_n)
		(regWr && regAddr == ADDR_OFFSETS) |=> ofs_q == $past(regWdata))
		else $error("offset write lost");
	a_crc_hold: assert property (@(posedge ref_clk) disable iff (!reset_n)
		(regWr && regAddr == ADDR_CRC_LO) |=> crcExp[1] == $past(regWdata[31:16]))
		else $error("crc pair write lost");
	a_rx_alive: assert property (@(posedge ref_clk) disable iff (!reset_n)
		rxAlive) else $error("receive path off");

	// a write that clears the power event status, one cycle
	sequence sPmClear;
		regWr && (regAddr == ADDR_PMCSR) && regWdata[PM_STATUS_BIT];
	endsequence
	// a write that clears the host wake flag, one cycle
	sequence sHostClear;
		regWr && (regAddr == ADDR_HOST_STAT) && regWdata[HOST_WAKE_BIT];
	endsequence

	// a clear with no wake beside it releases the status and its pin
	a_status_clear: assert property (@(posedge ref_clk) disable iff (!reset_n)
		sPmClear ##0 !wakeEv |=> !pmStat_q && power_event_out_n)
		else $error("power event status not cleared");
	// a clear with no wake beside it releases the host flag and interrupt
	a_host_clear: assert property (@(posedge ref_clk) disable iff (!reset_n)
		sHostClear ##0 !wakeEv |=> !wakeI_q && intA_n)
		else $error("host wake flag not cleared");
	// a wake in the clearing cycle keeps the status set
	a_set_wins: assert property (@(posedge ref_clk) disable iff (!reset_n)
		sPmClear ##0 wakeEv |=> pmStat_q && !power_event_out_n)
		else $error("clear beat a wake event");
	// a qualified pattern frame pulls the power event pin low
	a_pat_detect: assert property (@(posedge ref_clk) disable iff (!reset_n)
		(rxFrameEnd && (pstate_q != PM_D0) && power_event_enable_q && rxAddrMatch && !rxCrc32Err && (|hit))
		|=> !power_event_out_n) else $error("pattern frame missed");
	// status is sticky until software clears it
	a_status_sticky: assert property (@(posedge ref_clk) disable iff (!reset_n)
		(pmStat_q && !(regWr && (regAddr == ADDR_PMCSR) && regWdata[PM_STATUS_BIT])) |=> pmStat_q)
		else $error("power event status dropped");
	// state field and enable land on a control write
	a_pstate_write: assert property (@(posedge ref_clk) disable iff (!reset_n)
		(regWr && (regAddr == ADDR_PMCSR)) |=> (pstate_q == $past(regWdata[PM_STATE_LSB +: 2]))
			&& (power_event_enable_q == $past(regWdata[PM_ENABLE_BIT])))
		else $error("power state write lost");
	// the serial memory load installs the wake address
	a_id_load: assert property (@(posedge ref_clk) disable iff (!reset_n)
		idLoadValid |=> (wake_ident_address == $past(idLoadData)))
		else $error("wake address not loaded");
endmodule

// File: sim/wff_rx_model.sv
/*
 wff_rx_model: receive path model that hands frames to the wake filter.
 assumes: the bench fills frm and calls send from its main process.
*/
`timescale 1ns/1ns
module wff_rx_model (
	// clock
	input wire logic ref_clk,
	// byte stream
	output logic rxFrameStart,
	output logic rxByteValid,
	output logic [7:0] rxByteData,
	// frame status
	output logic rxFrameEnd,
	output logic rxAddrMatch,
	output logic rxCrc32Err
);
	// frame bytes, position 0 first
	logic [7:0] frm [0:63];
	// quiet outputs at time zero
	initial begin
		{rxFrameStart, rxByteValid, rxByteData, rxFrameEnd, rxAddrMatch, rxCrc32Err} = '0;
	end
	// start, bytes back to back, end one cycle after the last byte
	task send(input int len, input logic am, input logic ce);
		@(posedge ref_clk);
		rxFrameStart <= 1'b1;
		for (int i = 0; i < len; i++) begin
			@(posedge ref_clk);
			rxFrameStart <= 1'b0;
			rxByteValid <= 1'b1;
			rxByteData <= frm[i];
		end
		@(posedge ref_clk);
		rxByteValid <= 1'b0;
		rxByteData <= ~frm[len-1]; // stale byte never repeats
		rxFrameEnd <= 1'b1;
		rxAddrMatch <= am;
		rxCrc32Err <= ce;
		@(posedge ref_clk);
		rxFrameEnd <= 1'b0;
		rxAddrMatch <= ~am; // status only means something at frame end
		rxCrc32Err <= ~ce;
	endtask
endmodule

// File: sim/wake_frame_filter_pm_tb_top.sv
/*
 wake_frame_filter_pm_tb_top: self-checking bench for the wake filter.
 assumes: 250 MHz ref_clk, register reads answer one cycle later.
*/
`timescale 1ns/1ns
module wake_frame_filter_pm_tb_top
	import wff_pkg::*;
;
	// ----------------------------------------------------------------
	// stimulus and observed signals
	// ----------------------------------------------------------------
	logic ref_clk = 1'b0;
	logic reset_n = 1'b0;
	logic [5:0] regAddr = '0;
	logic [31:0] regWdata = '0;
	logic regWr = 1'b0;
	logic regRd = 1'b0;
	logic idLoadValid = 1'b0;
	logic [47:0] idLoadData = '0;
	logic magicDetect = 1'b0;
	logic linkChange = 1'b0;
	logic [31:0] regRdata;
	logic rxFrameStart, rxByteValid, rxFrameEnd, rxAddrMatch, rxCrc32Err;
	logic [7:0] rxByteData;
	logic intA_n, power_event_out_n, rxAlive;
	logic [47:0] wake_ident_address;
	logic rdPend = 1'b0; // a read answer is due this cycle
	logic [31:0] expQ [$]; // expected read data, oldest first
	int n_fail = 0;
	int samples_checked = 0;
	integer seed = 32'h68333527;

	// 4 ns clock
	initial forever #2 ref_clk = ~ref_clk;

	wff_wake_filter uut (.ref_clk(ref_clk), .reset_n(reset_n), .regAddr(regAddr),
		.regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
		.rxFrameStart(rxFrameStart), .rxByteValid(rxByteValid), .rxByteData(rxByteData),
		.rxFrameEnd(rxFrameEnd), .rxAddrMatch(rxAddrMatch), .rxCrc32Err(rxCrc32Err),
		.magicDetect(magicDetect), .linkChange(linkChange), .idLoadValid(idLoadValid),
		.idLoadData(idLoadData), .intA_n(intA_n), .power_event_out_n(power_event_out_n),
		.rxAlive(rxAlive), .wake_ident_address(wake_ident_address));

	wff_rx_model rx (.ref_clk(ref_clk), .rxFrameStart(rxFrameStart),
		.rxByteValid(rxByteValid), .rxByteData(rxByteData), .rxFrameEnd(rxFrameEnd),
		.rxAddrMatch(rxAddrMatch), .rxCrc32Err(rxCrc32Err));

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	// compare and count
	task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_fail++;
			$display("wrong value at %0t: got %h expected %h", $time, seen, exp);
		end
	endtask
	// verdict and end of run
	task stop_test;
		$display("comparisons %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	// one-cycle register write
	task wr(input logic [5:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		regAddr <= a;
		regWdata <= d;
		regWr <= 1'b1;
		@(posedge ref_clk);
		regWr <= 1'b0;
	endtask
	// one-cycle register read, answer noted for the monitor
	task rd(input logic [5:0] a, input logic [31:0] e);
		@(posedge ref_clk);
		regAddr <= a;
		regRd <= 1'b1;
		expQ.push_back(e);
		@(posedge ref_clk);
		regRd <= 1'b0;
	endtask
	// one-cycle pulse: 0 address load, 1 magic frame, 2 link change
	task pulse(input int k, input logic [47:0] d);
		@(posedge ref_clk);
		idLoadData <= d;
		idLoadValid <= (k == 0);
		magicDetect <= (k == 1);
		linkChange <= (k == 2);
		@(posedge ref_clk);
		{idLoadValid, magicDetect, linkChange} <= 3'h0;
	endtask
	// bounded wait for the wake pins, then compare both
	task expect_wake(input logic e);
		for (int n = 0; n < 6; n++) begin
			@(posedge ref_clk);
			#1;
			if (e && power_event_out_n === 1'b0) break;
		end
		chk(power_event_out_n, !e);
		chk(intA_n, !e);
	endtask
	// reflected crc-16 over the masked window of the model's frame
	function automatic logic [15:0] crc16(input int ofs, input logic [31:0] m);
		logic [15:0] c;
		c = CRC_SEED;
		for (int j = 0; j < WIN_BYTES; j++) begin
			if (m[j]) begin
				c = c ^ {8'h00, rx.frm[ofs + j]};
				for (int b = 0; b < 8; b++) begin
					c = c[0] ? ((c >> 1) ^ CRC_POLY_REV) : (c >> 1);
				end
			end
		end
		return c;
	endfunction

	// read monitor: oldest note against the answer cycle
	always @(posedge ref_clk) begin
		if (rdPend) begin
			chk(regRdata, expQ.pop_front());
		end else if (reset_n) begin
			chk(regRdata, 32'h0);
		end
		rdPend <= regRd;
	end

	// watchdog against a hang
	initial begin
		repeat (20000) @(posedge ref_clk);
		n_fail++;
		stop_test();
	end

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		logic [31:0] m, cw, pm, ow;
		logic [15:0] c;
		logic [5:0] aList [6];
		aList = '{ADDR_OFFSETS, ADDR_CRC_LO, ADDR_CRC_HI, ADDR_PMCSR, ADDR_HOST_STAT, 6'h3f};
		repeat (10) @(posedge ref_clk);
		reset_n <= 1'b1;
		@(posedge ref_clk);
		#1;
		chk(rxAlive, 1'b1);
		expect_wake(1'b0);
		// reset values, unmapped write ignored
		wr(6'h3f, 32'hffff_ffff);
		for (int i = 0; i < 6; i++) rd(aList[i], 32'h0);
		cw = $random(seed);
		wr(ADDR_CRC_LO, cw);
		rd(ADDR_CRC_LO, cw);
		cw = $random(seed);
		wr(ADDR_CRC_HI, cw);
		rd(ADDR_CRC_HI, cw);
		// wake address from serial memory
		m = $random(seed);
		pulse(0, {cw[15:0], m});
		@(posedge ref_clk);
		#1;
		chk(wake_ident_address, {cw[15:0], m});
		rd(ADDR_WAKE_ID_LO, m);
		rd(ADDR_WAKE_ID_HI, {16'h0000, cw[15:0]});
		for (int i = 0; i < 64; i++) rx.frm[i] = 8'($random(seed));
		// each filter alone, sleep states d1, d2, d3, d1
		for (int f = 0; f < NUM_FILTERS; f++) begin
			m = $random(seed);
			c = crc16(13 + f, m);
			ow = (32'(13 + f) | (32'h1 << EN_BIT)) << (f * FILT_STRIDE);
			cw = f[0] ? {c, ~c} : {~c, c};
			wr(ADDR_MASK0 + 6'(f), m);
			rd(ADDR_MASK0 + 6'(f), m);
			wr(f < 2 ? ADDR_CRC_LO : ADDR_CRC_HI, cw);
			pm = 32'h1 << PM_ENABLE_BIT;
			wr(ADDR_PMCSR, pm);
			pm = pm | 32'(f % 3 + 1);
			wr(ADDR_PMCSR, pm);
			// crc-32 error, wrong address, filter off, then a good frame
			for (int k = 0; k < 4; k++) begin
				wr(ADDR_OFFSETS, k == 2 ? ow & ~(32'h1 << (f * FILT_STRIDE + EN_BIT)) : ow);
				rx.send(64, k != 1, k == 0);
				expect_wake(k == 3);
			end
			rd(ADDR_OFFSETS, ow);
			rd(ADDR_PMCSR, pm | (32'h1 << PM_STATUS_BIT));
			rd(ADDR_HOST_STAT, 32'h1 << HOST_WAKE_BIT);
			wr(ADDR_PMCSR, pm | (32'h1 << PM_STATUS_BIT));
			wr(ADDR_HOST_STAT, 32'h1 << HOST_WAKE_BIT);
			expect_wake(1'b0);
		end
		// fully on: matching frame and magic frame both ignored
		wr(ADDR_PMCSR, 32'h1 << PM_ENABLE_BIT);
		rx.send(64, 1'b1, 1'b0);
		expect_wake(1'b0);
		pulse(1, idLoadData);
		expect_wake(1'b0);
		// magic frame and link change asleep, then with enable off
		for (int k = 1; k < 3; k++) begin
			wr(ADDR_PMCSR, (32'h1 << PM_ENABLE_BIT) | 32'(PS_D3));
			pulse(k, idLoadData);
			expect_wake(1'b1);
			// status clear in the same cycle as a new wake: the set wins
			fork
				wr(ADDR_PMCSR, (32'h1 << PM_STATUS_BIT) | (32'h1 << PM_ENABLE_BIT) | 32'(PS_D3));
				pulse(k, idLoadData);
			join
			expect_wake(1'b1);
			wr(ADDR_PMCSR, (32'h1 << PM_STATUS_BIT) | 32'(PS_D3));
			wr(ADDR_HOST_STAT, 32'h1 << HOST_WAKE_BIT);
			pulse(k, idLoadData);
			expect_wake(1'b0);
		end
		repeat (2) @(posedge ref_clk);
		chk(expQ.size(), 0);
		stop_test();
	end
endmodule
